/* logic/hwrc_top.v */
// halt, wake-up and reset sequencer with apb register access
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/100ps
`include "hwrc_defs.vh"
module hwrc_top
(
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // core events
  input wire halt_instr,
  input wire watchdog_clear_instruction,
  input wire stack_full,
  input wire [2:0] irq_req,
  // wake sources
  input wire external_reset_pin_n,
  input wire [7:0] port_a_in,
  input wire wdt_overflow,
  // sequencing outputs
  output wire sys_osc_en,
  output wire cpu_run,
  output wire chip_reset,
  output reg warm_reset,
  output reg sp_reset,
  output reg wdt_clear,
  output reg resume_next,
  output reg int_ack,
  output reg [2:0] int_ack_src,
  output reg timeout_flag,
  output reg powerdown_flag,
  // managed registers
  output reg [7:0] interrupt_control_reg,
  output reg [7:0] timer_control_reg,
  output reg [7:0] converter_control_reg,
  output reg [7:0] amplifier_control_reg,
  output reg [7:0] port_a_data,
  output reg [7:0] port_a_direction_reg,
  output reg [7:0] program_counter_low
);

  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam [2:0] ST_RUN = 3'd0;
  localparam [2:0] ST_RSTHOLD = 3'd1;
  localparam [2:0] ST_CFGLOAD = 3'd2;
  localparam [2:0] ST_STARTUP = 3'd3;
  localparam [2:0] ST_HALT = 3'd4;
  localparam [2:0] ST_ACKDLY = 3'd5;

  localparam [10:0] STARTUP_LAST = `HWRC_STARTUP_CYCLES - 11'd1;
  localparam [10:0] OPT_LAST = `HWRC_OPT_LOAD_CYCLES - 11'd1;

  reg [2:0] state_r;
  reg [10:0] cnt_r;
  reg [8:0] cfg_r;
  reg [2:0] halt_mask_r;
  reg [7:0] pa_prev_r;
  reg wake_int_r;
  reg [2:0] wake_src_r;

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function apb_hit;
    input [7:0] a;
    begin
      apb_hit = (a == `HWRC_A_CFG) || (a == `HWRC_A_STAT) || (a == `HWRC_A_IRQCTL) ||
                (a == `HWRC_A_TIMCTL) || (a == `HWRC_A_CNVCTL) || (a == `HWRC_A_AMPCTL) ||
                (a == `HWRC_A_PORTDAT) || (a == `HWRC_A_PORTDIR) || (a == `HWRC_A_PCLOW);
    end
  endfunction

  // lowest index wins, matching interrupt priority
  function [2:0] first_bit;
    input [2:0] v;
    begin
      if (v[0])
        first_bit = 3'b001;
      else if (v[1])
        first_bit = 3'b010;
      else if (v[2])
        first_bit = 3'b100;
      else
        first_bit = 3'b000;
    end
  endfunction

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  wire acc = psel & penable;
  wire hit = apb_hit(paddr);
  wire wr = acc & pwrite & hit;
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;

  // ------------------------------------------------------------
  // event decode
  // ------------------------------------------------------------
  wire in_halt = (state_r == ST_HALT);
  wire running = (state_r == ST_RUN);
  wire ext_rst = ~external_reset_pin_n;
  wire [2:0] irq_flags = interrupt_control_reg[`HWRC_IRQ_RQ_LO +: 3];
  wire [2:0] irq_ens = interrupt_control_reg[`HWRC_IRQ_EN_LO +: 3];
  wire irq_emi = interrupt_control_reg[`HWRC_IRQ_MASTER];
  wire [7:0] pa_fall = pa_prev_r & ~port_a_in & cfg_r[7:0];
  // flags present at halt entry are masked
  wire [2:0] irq_wake = (irq_flags | irq_req) & ~halt_mask_r;
  // external reset wins over a wake-up in progress
  wire full_ext = ext_rst;
  // overflow while running is a full reset
  wire full_wdt = running & wdt_overflow & ~ext_rst;
  wire full_rst = full_ext | full_wdt;
  wire warm_evt = in_halt & wdt_overflow & ~ext_rst;
  wire wake_evt = in_halt & ~ext_rst & ~wdt_overflow & ((|pa_fall) | (|irq_wake));
  wire halt_go = running & halt_instr & ~full_rst;
  wire [2:0] ack_pick = first_bit(wake_src_r & irq_ens);

  assign sys_osc_en = ~in_halt;
  assign cpu_run = running;
  assign chip_reset = (state_r == ST_RSTHOLD) | (state_r == ST_CFGLOAD);

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= ST_CFGLOAD;
      cnt_r <= 11'd0;
      halt_mask_r <= 3'b000;
      wake_int_r <= 1'b0;
      wake_src_r <= 3'b000;
      pa_prev_r <= 8'hff;
      warm_reset <= 1'b0;
      sp_reset <= 1'b1;
      wdt_clear <= 1'b1;
      resume_next <= 1'b0;
      int_ack <= 1'b0;
      int_ack_src <= 3'b000;
    end
    else
    begin
      pa_prev_r <= port_a_in;
      warm_reset <= 1'b0;
      sp_reset <= 1'b0;
      wdt_clear <= 1'b0;
      resume_next <= 1'b0;
      int_ack <= 1'b0;
      cnt_r <= cnt_r + 11'd1;
      if (full_rst)
      begin
        // chip reset clears watchdog and stack
        wdt_clear <= 1'b1;
        sp_reset <= 1'b1;
        cnt_r <= 11'd0;
        state_r <= ext_rst ? ST_RSTHOLD : ST_CFGLOAD;
      end
      else
      begin
        case (state_r)
          ST_RSTHOLD:
          begin
            cnt_r <= 11'd0;
            state_r <= ST_CFGLOAD;
          end
          ST_CFGLOAD:
          begin
            // option load only on full resets
            if (cnt_r == OPT_LAST)
            begin
              cnt_r <= 11'd0;
              wake_int_r <= 1'b0;
              state_r <= ST_STARTUP;
            end
          end
          ST_STARTUP:
          begin
            if (cnt_r == STARTUP_LAST)
            begin
              cnt_r <= 11'd0;
              if (wake_int_r && irq_emi && (|ack_pick) && !stack_full)
                state_r <= ST_ACKDLY;
              else
              begin
                resume_next <= 1'b1;
                state_r <= ST_RUN;
              end
            end
          end
          ST_ACKDLY:
          begin
            int_ack <= 1'b1;
            int_ack_src <= ack_pick;
            state_r <= ST_RUN;
          end
          ST_RUN:
          begin
            if (halt_go)
            begin
              wdt_clear <= cfg_r[`HWRC_CFG_WOSC];
              halt_mask_r <= irq_flags;
              state_r <= ST_HALT;
            end
          end
          ST_HALT:
          begin
            cnt_r <= 11'd0;
            if (warm_evt)
            begin
              // warm wake-up resets counter and stack only
              warm_reset <= 1'b1;
              sp_reset <= 1'b1;
              wake_int_r <= 1'b0;
              state_r <= ST_STARTUP;
            end
            else if (wake_evt)
            begin
              wake_int_r <= (|irq_wake) & ~(|pa_fall);
              wake_src_r <= irq_wake;
              state_r <= ST_STARTUP;
            end
          end
          default:
          begin
            state_r <= ST_CFGLOAD;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // status flags
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timeout_flag <= 1'b0;
      powerdown_flag <= 1'b0;
    end
    else
    begin
      if (halt_go)
      begin
        powerdown_flag <= 1'b1;
        timeout_flag <= 1'b0;
      end
      else if (in_halt && ext_rst)
      begin
        timeout_flag <= 1'b0;
        powerdown_flag <= 1'b1;
      end
      else if (warm_evt)
      begin
        timeout_flag <= 1'b1;
        powerdown_flag <= 1'b1;
      end
      else if (full_wdt)
      begin
        timeout_flag <= 1'b1;
      end
      else if (running && watchdog_clear_instruction)
      begin
        powerdown_flag <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // managed registers and configuration
  // ------------------------------------------------------------
  // writes other than config land only while running so halted state is held
  wire rw = wr & running;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_r <= `HWRC_RV_CFG;
      interrupt_control_reg <= `HWRC_RV_IRQCTL;
      timer_control_reg <= `HWRC_RV_TIMCTL;
      converter_control_reg <= `HWRC_RV_CNVCTL;
      amplifier_control_reg <= `HWRC_RV_AMPCTL;
      port_a_data <= `HWRC_RV_PORT;
      port_a_direction_reg <= `HWRC_RV_PORT;
      program_counter_low <= `HWRC_RV_PCLOW;
    end
    else if (full_rst)
    begin
      timer_control_reg <= `HWRC_RV_TIMCTL;
      converter_control_reg <= `HWRC_RV_CNVCTL;
      amplifier_control_reg <= `HWRC_RV_AMPCTL;
      port_a_data <= `HWRC_RV_PORT;
      port_a_direction_reg <= `HWRC_RV_PORT;
      program_counter_low <= `HWRC_RV_PCLOW;
      interrupt_control_reg <= `HWRC_RV_IRQCTL;
    end
    else if (warm_evt)
    begin
      program_counter_low <= `HWRC_RV_PCLOW;
    end
    else
    begin
      if (wr && paddr == `HWRC_A_CFG)
        cfg_r <= pwdata[8:0];
      if (rw && paddr == `HWRC_A_IRQCTL)
        interrupt_control_reg <= (pwdata[7:0] & `HWRC_IRQ_MASK) |
                                 {1'b0, irq_req, 4'h0};
      // acknowledge drops master enable and taken flag
      else if (state_r == ST_ACKDLY)
        interrupt_control_reg <= (interrupt_control_reg & ~{1'b0, ack_pick, 3'b000, 1'b1}) |
                                 {1'b0, irq_req, 4'h0};
      else
        interrupt_control_reg <= interrupt_control_reg | {1'b0, irq_req, 4'h0};
      if (rw && paddr == `HWRC_A_TIMCTL)
        timer_control_reg <= pwdata[7:0];
      if (rw && paddr == `HWRC_A_CNVCTL)
        converter_control_reg <= pwdata[7:0];
      if (rw && paddr == `HWRC_A_AMPCTL)
        amplifier_control_reg <= pwdata[7:0];
      if (rw && paddr == `HWRC_A_PORTDAT)
        port_a_data <= pwdata[7:0];
      if (rw && paddr == `HWRC_A_PORTDIR)
        port_a_direction_reg <= pwdata[7:0];
      if (rw && paddr == `HWRC_A_PCLOW)
        program_counter_low <= pwdata[7:0];
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  reg [31:0] rd_nxt;

  always @*
  begin
    rd_nxt = 32'h0000_0000;
    case (paddr)
      `HWRC_A_CFG: rd_nxt = {23'h000000, cfg_r};
      `HWRC_A_STAT: rd_nxt = {24'h000000, 1'b0, state_r, 2'b00, timeout_flag, powerdown_flag};
      `HWRC_A_IRQCTL: rd_nxt = {24'h000000, interrupt_control_reg};
      `HWRC_A_TIMCTL: rd_nxt = {24'h000000, timer_control_reg};
      `HWRC_A_CNVCTL: rd_nxt = {24'h000000, converter_control_reg};
      `HWRC_A_AMPCTL: rd_nxt = {24'h000000, amplifier_control_reg};
      `HWRC_A_PORTDAT: rd_nxt = {24'h000000, port_a_data};
      `HWRC_A_PORTDIR: rd_nxt = {24'h000000, port_a_direction_reg};
      `HWRC_A_PCLOW: rd_nxt = {24'h000000, program_counter_low};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_nxt;
  end

endmodule

/* common/hwrc_defs.vh */
// constants for the halt, wake-up and reset sequencer
// Operation
// - halt stops system oscillator, watchdog oscillator runs
// - halted state keeps memory, registers, ports
// - halt clears watchdog when on own oscillator
// - halt sets powerdown flag, clears timeout flag
// - wake on reset, interrupt, pin edge, overflow
// - power-up or watchdog clear clears powerdown flag
// - timeout sets flag; halted timeout is warm
// - each port A bit enables wake-up
// - pin wake-up resumes at next instruction
// - interrupt wake resumes or responds by enables
// - flag already set at halt cannot wake
// - 1024 clock start-up delay after wake, reset
// - resume immediately; interrupt entry one cycle later
// - configuration-load delay on full resets only
// - timeout and powerdown flags encode reset cause
// - chip reset clears counter, ports input, timer off
// - running watchdog timeout is full chip reset
// - full resets load fixed register values
// - full resets clear interrupt control register
// - overflow running resets chip, halted warm-resets
`ifndef HWRC_DEFS_VH
`define HWRC_DEFS_VH

// apb byte addresses
`define HWRC_A_CFG 8'h00
`define HWRC_A_STAT 8'h04
`define HWRC_A_IRQCTL 8'h08
`define HWRC_A_TIMCTL 8'h0c
`define HWRC_A_CNVCTL 8'h10
`define HWRC_A_AMPCTL 8'h14
`define HWRC_A_PORTDAT 8'h18
`define HWRC_A_PORTDIR 8'h1c
`define HWRC_A_PCLOW 8'h20

// reset values
`define HWRC_RV_PCLOW 8'h00
`define HWRC_RV_PORT 8'hff
`define HWRC_RV_TIMCTL 8'h08
`define HWRC_RV_CNVCTL 8'h40
`define HWRC_RV_AMPCTL 8'h08
`define HWRC_RV_IRQCTL 8'h00
`define HWRC_RV_CFG 9'h100

// interrupt control fields
`define HWRC_IRQ_MASTER 0
`define HWRC_IRQ_EN_LO 1
`define HWRC_IRQ_RQ_LO 4
`define HWRC_IRQ_MASK 8'h7f
// config: bits 7:0 wake enables, bit 8 watchdog on own oscillator
`define HWRC_CFG_WOSC 8

// timing
`define HWRC_STARTUP_CYCLES 11'd1024
`define HWRC_OPT_LOAD_CYCLES 11'd16

`endif

/* tb/hwrc_checker.sv */
// assertion checker for the halt, wake-up and reset sequencer
`timescale 1ns/100ps
`include "hwrc_defs.vh"
module hwrc_checker
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // core and wake inputs
  input wire logic halt_instr,
  input wire logic watchdog_clear_instruction,
  input wire logic external_reset_pin_n,
  input wire logic wdt_overflow,
  // sequencing outputs
  input wire logic sys_osc_en,
  input wire logic cpu_run,
  input wire logic chip_reset,
  input wire logic warm_reset,
  input wire logic sp_reset,
  input wire logic resume_next,
  input wire logic int_ack,
  input wire logic timeout_flag,
  input wire logic powerdown_flag,
  // managed registers
  input wire logic [7:0] interrupt_control_reg,
  input wire logic [7:0] timer_control_reg,
  input wire logic [7:0] converter_control_reg,
  input wire logic [7:0] amplifier_control_reg,
  input wire logic [7:0] port_a_data,
  input wire logic [7:0] port_a_direction_reg,
  input wire logic [7:0] program_counter_low
);
  // ----------------------------------------
  // cycles spent stalled with oscillator on
  // ----------------------------------------
  reg [10:0] idle_r;
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      idle_r <= 11'h000;
    else if (cpu_run || chip_reset || !sys_osc_en)
      idle_r <= 11'h000;
    else
      idle_r <= idle_r + 11'h001;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_halt;
    cpu_run && halt_instr;
  endsequence
  sequence s_halted;
    !sys_osc_en && external_reset_pin_n;
  endsequence
  a_halt_osc_off: assert property (s_halt |=> !sys_osc_en && !cpu_run)
    else $error("oscillator still on after halt");
  a_halt_flags: assert property (s_halt |=> powerdown_flag && !timeout_flag)
    else $error("flags wrong after halt");
  a_halt_hold: assert property (!sys_osc_en ##1 !sys_osc_en |-> $stable(port_a_data) &&
    $stable(timer_control_reg) && $stable(program_counter_low))
    else $error("state changed while halted");
  a_warm_only: assert property (warm_reset |-> program_counter_low == `HWRC_RV_PCLOW && sp_reset &&
    !chip_reset && timeout_flag && powerdown_flag)
    else $error("warm reset wrong");
  a_ovf_halted: assert property ((s_halted and wdt_overflow) |=> warm_reset)
    else $error("no warm reset on halted overflow");
  a_pin_halted: assert property (!sys_osc_en && !external_reset_pin_n |=> chip_reset &&
    !timeout_flag && powerdown_flag)
    else $error("pin wake from halt wrong");
  a_ovf_running: assert property (cpu_run && wdt_overflow && external_reset_pin_n && !halt_instr &&
    !watchdog_clear_instruction |=> chip_reset && timeout_flag && powerdown_flag == $past(powerdown_flag))
    else $error("running overflow wrong");
  a_clear_pdf: assert property (cpu_run && watchdog_clear_instruction && !halt_instr |=> !powerdown_flag)
    else $error("powerdown flag not cleared");
  a_sst_len: assert property (resume_next |-> idle_r == 11'h400)
    else $error("start-up delay length wrong");
  a_ack_delay: assert property (int_ack |-> idle_r == 11'h401)
    else $error("interrupt entry delay wrong");
  a_reset_vals: assert property ($fell(chip_reset) |-> interrupt_control_reg == `HWRC_RV_IRQCTL &&
    timer_control_reg == `HWRC_RV_TIMCTL && converter_control_reg == `HWRC_RV_CNVCTL &&
    amplifier_control_reg == `HWRC_RV_AMPCTL && port_a_data == `HWRC_RV_PORT &&
    port_a_direction_reg == `HWRC_RV_PORT && program_counter_low == `HWRC_RV_PCLOW)
    else $error("reset values wrong");
endmodule
bind hwrc_top hwrc_checker hwrc_checker_inst (.pclk, .presetn, .halt_instr, .watchdog_clear_instruction,
  .external_reset_pin_n, .wdt_overflow, .sys_osc_en, .cpu_run, .chip_reset, .warm_reset, .sp_reset,
  .resume_next, .int_ack, .timeout_flag, .powerdown_flag, .interrupt_control_reg, .timer_control_reg,
  .converter_control_reg, .amplifier_control_reg, .port_a_data, .port_a_direction_reg, .program_counter_low);

/* tb/hwrc_partner.sv */
// model of the reset pin, port a wake pins and watchdog
`timescale 1ns/100ps
module hwrc_partner
(
  // clock and commands
  input wire logic pclk,
  input wire logic pin_low_req,
  input wire logic [7:0] fall_req,
  input wire logic ovf_req,
  // pins toward the device
  output logic external_reset_pin_n,
  output logic [7:0] port_a_in,
  output logic wdt_overflow
);
  logic [2:0] hold_r;
  initial
  begin
    external_reset_pin_n = 1'b1;
    port_a_in = 8'hff;
    wdt_overflow = 1'b0;
    hold_r = 3'h0;
  end
  // pulled-up pins dip low on request, then return high
  always @(posedge pclk)
  begin
    external_reset_pin_n <= !pin_low_req;
    wdt_overflow <= ovf_req;
    if (fall_req != 8'h00)
    begin
      port_a_in <= ~fall_req;
      hold_r <= 3'h4;
    end
    else if (hold_r != 3'h0)
      hold_r <= hold_r - 3'h1;
    else
      port_a_in <= 8'hff;
  end
endmodule

/* tb/tb_top.sv */
// self-checking bench for the halt, wake-up and reset sequencer
`timescale 1ns/100ps
`include "hwrc_defs.vh"
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic halt_instr, watchdog_clear_instruction, stack_full, pin_low_req, ovf_req;
  logic sys_osc_en, cpu_run, chip_reset, resume_next, int_ack, timeout_flag, powerdown_flag, wdt_clear;
  logic external_reset_pin_n, wdt_overflow, exp_to, exp_pd;
  logic [7:0] paddr, fall_req, port_a_in;
  logic [2:0] irq_req, int_ack_src, src;
  logic [31:0] pwdata, prdata, q, d;
  logic [7:0] ict [0:2] = '{8'h03, 8'h05, 8'h08};
  integer rv [2:8] = '{`HWRC_RV_IRQCTL, `HWRC_RV_TIMCTL, `HWRC_RV_CNVCTL, `HWRC_RV_AMPCTL, `HWRC_RV_PORT,
    `HWRC_RV_PORT, `HWRC_RV_PCLOW};
  integer exp_r [2:8];
  integer mismatches, check_count, seed, i, k, rn, ia;
  hwrc_top hwrc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .halt_instr, .watchdog_clear_instruction, .stack_full, .irq_req, .external_reset_pin_n,
    .port_a_in, .wdt_overflow, .sys_osc_en, .cpu_run, .chip_reset, .warm_reset(), .sp_reset(),
    .wdt_clear, .resume_next, .int_ack, .int_ack_src, .timeout_flag, .powerdown_flag,
    .interrupt_control_reg(), .timer_control_reg(), .converter_control_reg(), .amplifier_control_reg(),
    .port_a_data(), .port_a_direction_reg(), .program_counter_low());
  hwrc_partner hwrc_partner_inst (.pclk, .pin_low_req, .fall_req, .ovf_req, .external_reset_pin_n,
    .port_a_in, .wdt_overflow);
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] e, input logic [31:0] g);
    check_count = check_count + 1;
    if (g !== e)
    begin
      mismatches = mismatches + 1;
      $display("unexpected %s: expected %h seen %h", name, e, g);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    integer n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      n = n + 1;
      if (n > 50)
      begin
        mismatches = mismatches + 1;
        wrap_up;
      end
      @(posedge pclk);
    end
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task pulse(input integer kind, input logic [7:0] v);
    @(posedge pclk);
    case (kind)
      0: halt_instr <= 1'b1;
      1: watchdog_clear_instruction <= 1'b1;
      2: irq_req <= v[2:0];
      3: fall_req <= v;
      default: ovf_req <= 1'b1;
    endcase
    @(posedge pclk);
    halt_instr <= 1'b0;
    watchdog_clear_instruction <= 1'b0;
    irq_req <= 3'h0;
    fall_req <= 8'h00;
    ovf_req <= 1'b0;
    #1;
  endtask
  task halt;
    pulse(0, 8'h00);
    exp_to = 1'b0;
    exp_pd = 1'b1;
    chk("timeout flag", exp_to, timeout_flag); // halt flags
    chk("powerdown flag", exp_pd, powerdown_flag); // halt flags
    chk("oscillator enable", 0, sys_osc_en); // oscillator stopped
    chk("watchdog clear", 1, wdt_clear); // watchdog restart
  endtask
  task full_model;
    for (i = 2; i < 9; i = i + 1)
      exp_r[i] = rv[i];
  endtask
  task rand_regs;
    for (i = 2; i < 9; i = i + 1)
    begin
      d = $random(seed);
      exp_r[i] = (i == 2) ? d[6:0] : d[7:0];
      apb(1'b1, {i[5:0], 2'b00}, d);
    end
  endtask
  task chk_regs;
    for (i = 2; i < 9; i = i + 1)
    begin
      apb(1'b0, {i[5:0], 2'b00}, 32'h0);
      chk($sformatf("register %0h", i * 4), exp_r[i], q);
    end
    apb(1'b0, `HWRC_A_STAT, 32'h0);
    chk("status flags", {exp_to, exp_pd}, q[1:0]);
  endtask
  task pin_reset;
    @(posedge pclk);
    pin_low_req <= 1'b1;
    repeat (5) @(posedge pclk);
    pin_low_req <= 1'b0;
    full_model;
  endtask
  task wait_run;
    integer n;
    n = 0;
    rn = 0;
    ia = 0;
    while (cpu_run === 1'b1 && n < 20)
    begin
      @(posedge pclk);
      #1;
      n = n + 1;
    end
    while (cpu_run !== 1'b1)
    begin
      @(posedge pclk);
      #1;
      if (resume_next === 1'b1)
        rn = 1;
      if (int_ack === 1'b1)
      begin
        ia = 1;
        src = int_ack_src;
      end
      n = n + 1;
      if (n > 3000)
      begin
        mismatches = mismatches + 1;
        wrap_up;
      end
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    seed = 32'hf6e180c2;
    mismatches = 0;
    check_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    halt_instr = 1'b0;
    watchdog_clear_instruction = 1'b0;
    stack_full = 1'b0;
    irq_req = 3'h0;
    pin_low_req = 1'b0;
    fall_req = 8'h00;
    ovf_req = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    full_model;
    exp_to = 1'b0;
    exp_pd = 1'b0;
    wait_run;
    chk("resume after reset", 1, rn); // start-up delay
    chk_regs; // reset values
    rand_regs;
    apb(1'b1, `HWRC_A_STAT, 32'h3);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped error", 1, perr);
    chk("unmapped data", 0, q);
    chk_regs;
    $display("test reset and registers done");
    apb(1'b1, `HWRC_A_CFG, 32'h101);
    halt; // halt entry
    pulse(3, 8'h02);
    repeat (10) @(posedge pclk);
    chk("disabled pin stays halted", 0, sys_osc_en); // wake enables
    pulse(3, 8'h01);
    wait_run;
    chk("pin wake resume", 1, rn); // pin wake
    chk_regs; // state kept
    pulse(1, 8'h00);
    exp_pd = 1'b0;
    chk("powerdown flag", exp_pd, powerdown_flag); // flag clear
    $display("test port wake done");
    for (k = 0; k < 3; k = k + 1)
    begin
      d = ict[k];
      apb(1'b1, `HWRC_A_IRQCTL, d);
      stack_full <= (k == 1);
      halt;
      pulse(2, 8'h01 << k);
      wait_run;
      chk("interrupt ack", k == 0, ia); // interrupt wake
      chk("resume next", k != 0, rn); // resume
      if (k == 0)
        chk("ack source", 3'h1, src); // ack source
      exp_r[2] = (k == 0) ? 32'h02 : d | (32'h10 << k);
      chk_regs; // flag state
    end
    stack_full <= 1'b0;
    $display("test interrupt wake done");
    apb(1'b1, `HWRC_A_PCLOW, 32'h5a);
    exp_r[8] = 32'h5a;
    halt;
    pulse(2, 8'h04);
    repeat (20) @(posedge pclk);
    chk("pending flag no wake", 0, sys_osc_en); // masked wake
    pulse(4, 8'h00);
    exp_r[8] = 0;
    exp_to = 1'b1;
    wait_run;
    chk("warm resume", 1, rn); // warm wake
    chk_regs; // warm state
    rand_regs;
    pulse(4, 8'h00);
    full_model;
    wait_run;
    chk_regs; // running overflow
    $display("test watchdog done");
    rand_regs;
    pin_reset;
    wait_run;
    chk_regs; // pin in run
    rand_regs;
    halt;
    pin_reset;
    wait_run;
    chk_regs; // pin in halt
    apb(1'b1, `HWRC_A_CFG, 32'h101);
    rand_regs;
    halt;
    pulse(3, 8'h01);
    repeat (100) @(posedge pclk);
    pin_reset;
    wait_run;
    chk_regs; // pin during start-up
    $display("test pin reset done");
    wrap_up;
  end
endmodule
